// *** psh_regs.svh ***
// timing counts and widths for the port strobe handshake block
`ifndef PSH_REGS_SVH
`define PSH_REGS_SVH
// delay and length counts are cycles of the processor output clock (clk); the queue depth is in entries
`define PSH_STB_CYC 2
`define PSH_WR_DLY 2
`define PSH_RD_DLY 3
`define PSH_XM_STB_BASE 1
`define PSH_PF_CYC 2
`define PSH_Q_DEPTH 4
`define PSH_Q_AW 2
`define PSH_TS_W 8
`define PSH_RST_PORT 8'h00
`define PSH_RST_ADDR 16'h0000
`endif

// *** psh_pkg.sv ***
// types shared by the port strobe handshake modules
`default_nettype none
`include "psh_regs.svh"
package psh_pkg;
  typedef enum logic [2:0]
  {
    PG_IDLE = 3'b001,
    PG_FIRST = 3'b010,
    PG_SECOND = 3'b100
  } psh_pg_state_t;
  typedef enum logic [3:0]
  {
    XM_IDLE = 4'b0001,
    XM_ADDR = 4'b0010,
    XM_STB = 4'b0100,
    XM_FETCH = 4'b1000
  } psh_xm_state_t;
  typedef struct packed
  {
    logic is_wr;
    logic also_rd;
    logic [`PSH_TS_W-1:0] due;
  } psh_pend_t;
endpackage
`default_nettype wire

// *** psh_q_if.sv ***
// pending strobe queue connection
`timescale 1ns/10ps
`default_nettype none
interface psh_q_if;
  import psh_pkg::*;
  logic push;
  psh_pend_t push_data;
  logic pop;
  psh_pend_t head;
  logic not_empty;
  logic full;
  modport owner (output push, output push_data, output pop,
    input head, input not_empty, input full);
  modport queue (input push, input push_data, input pop,
    output head, output not_empty, output full);
endinterface
`default_nettype wire

// *** psh_pend_queue.sv ***
// small in-order queue of pending port strobes with registered head
`timescale 1ns/10ps
`default_nettype none
module psh_pend_queue
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  psh_q_if.queue q
);
  import psh_pkg::*;
  psh_pend_t mem [`PSH_Q_DEPTH];
  logic [`PSH_Q_AW-1:0] wr_ptr;
  logic [`PSH_Q_AW-1:0] rd_ptr;
  logic [`PSH_Q_AW:0] count;
  logic push_ok;
  logic pop_ok;

  assign push_ok = q.push && !q.full;
  assign pop_ok = q.pop && q.not_empty;
  assign q.not_empty = (count != '0);
  assign q.full = (count == (`PSH_Q_AW+1)'(`PSH_Q_DEPTH));

  always_ff @(posedge clk)
  begin
    if (ce && push_ok)
    begin
      mem[wr_ptr] <= q.push_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else if (ce)
    begin
      if (push_ok)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop_ok)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push_ok && !pop_ok)
      begin
        count <= count + 1'b1;
      end
      else if (pop_ok && !push_ok)
      begin
        count <= count - 1'b1;
      end
    end
  end

  // head always mirrors the oldest entry
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q.head <= '0;
    end
    else if (ce)
    begin
      if (push_ok && (count == '0 || (pop_ok && count == 1)))
      begin
        q.head <= q.push_data;
      end
      else if (pop_ok && count > 1)
      begin
        q.head <= mem[rd_ptr + 1'b1];
      end
    end
  end
endmodule
`default_nettype wire

// *** psh_top.sv ***
// port strobe handshake and external data memory strobe sequencing
// Function
// [R1] port accesses strobe read/write pins only while strobe enable is set
// [R2] each port strobe stays asserted exactly two clock cycles
// [R3] write strobe starts two cycles after the port is updated
// [R4] port read returns pins latched three cycles before read strobe
// [R5] read strobe starts three cycles after the processor port read
// [R6] nothing is sampled when the read strobe asserts
// [R7] peripheral may change port data only after the read strobe pulse
// [R8] first pointer address driven only while a strobe is active
// [R9] second pointer address held valid for the whole memory cycle
// [R10] stretch lengthens data memory cycles only, not program fetches
// [R11] strobes are active low and idle high
// [R12] back-to-back accesses each get a full pulse, in access order; an access made with the 4-entry queue full gets no pulse
`timescale 1ns/10ps
`default_nettype none
`include "psh_regs.svh"
module psh_top
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic port_strobe_enable,
  input wire logic cpu_port_wr,
  input wire logic [7:0] cpu_port_wr_data,
  input wire logic cpu_port_rd,
  input wire logic [7:0] port_drive,
  input wire logic [7:0] port_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe,
  output logic [7:0] cpu_rd_data,
  input wire logic xmem_req,
  input wire logic xmem_write,
  input wire logic xmem_use_second,
  input wire logic [15:0] first_auto_pointer,
  input wire logic [15:0] second_auto_pointer,
  input wire logic [2:0] stretch,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic rd_strobe_n,
  output logic wr_strobe_n,
  output logic prog_fetch_n,
  output logic [15:0] xmem_addr,
  output logic xmem_addr_oe,
  output logic xmem_busy
);
  import psh_pkg::*;

  function automatic logic due_reached(input logic [`PSH_TS_W-1:0] now,
    input logic [`PSH_TS_W-1:0] due);
    logic [`PSH_TS_W-1:0] diff;
    diff = now - due;
    due_reached = !diff[`PSH_TS_W-1];
  endfunction

  // ==========================================================
  // port side and access capture
  psh_q_if qif ();
  psh_pend_queue u_queue
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .q(qif)
  );

  logic [`PSH_TS_W-1:0] now;
  psh_pg_state_t pg_state;
  psh_pg_state_t next_pg_state;
  logic pg_is_wr;
  logic next_port_rd;
  logic next_port_wr;
  // read pulse still owed by a combined write and read access
  logic rd_follow;
  logic pick_wr;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      now <= '0;
    end
    else if (ce)
    begin
      now <= now + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port_out <= `PSH_RST_PORT;
      port_oe <= 8'h00;
    end
    else if (ce)
    begin
      port_oe <= port_drive;
      if (cpu_port_wr)
      begin
        port_out <= cpu_port_wr_data;
      end
    end
  end

  // read data are the pins at the read itself, three cycles ahead
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cpu_rd_data <= 8'h00;
    end
    else if (ce && cpu_port_rd)
    begin
      cpu_rd_data <= port_in; // [R4] [R6]
    end
  end

  // a read and a write in one cycle share one entry: write pulse, then read
  always_comb
  begin
    qif.push = port_strobe_enable && (cpu_port_wr || cpu_port_rd); // [R1]
    qif.push_data.is_wr = cpu_port_wr;
    qif.push_data.also_rd = cpu_port_wr && cpu_port_rd; // [R12]
    if (cpu_port_wr)
    begin
      qif.push_data.due = now + `PSH_TS_W'(`PSH_WR_DLY); // [R3]
    end
    else
    begin
      qif.push_data.due = now + `PSH_TS_W'(`PSH_RD_DLY); // [R5]
    end
  end

  // ==========================================================
  // port strobe pulse generator
  always_comb
  begin
    next_pg_state = pg_state;
    qif.pop = 1'b0;
    pick_wr = qif.head.is_wr && !rd_follow;
    case (pg_state)
      PG_IDLE:
      begin
        if (!port_strobe_enable)
        begin
          qif.pop = qif.not_empty; // stale entries are dropped
        end
        else if (rd_follow)
        begin
          next_pg_state = PG_FIRST; // [R12]
        end
        else if (qif.not_empty && due_reached(now, qif.head.due)) // [R12]
        begin
          qif.pop = 1'b1;
          next_pg_state = PG_FIRST;
        end
      end
      PG_FIRST:
      begin
        next_pg_state = PG_SECOND; // [R2]
      end
      PG_SECOND:
      begin
        next_pg_state = PG_IDLE;
      end
      default:
      begin
        next_pg_state = PG_IDLE;
      end
    endcase
    next_port_rd = (next_pg_state != PG_IDLE) &&
      ((pg_state == PG_IDLE) ? !pick_wr : !pg_is_wr);
    next_port_wr = (next_pg_state != PG_IDLE) &&
      ((pg_state == PG_IDLE) ? pick_wr : pg_is_wr);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pg_state <= PG_IDLE;
      pg_is_wr <= 1'b0;
      rd_follow <= 1'b0;
    end
    else if (ce)
    begin
      pg_state <= next_pg_state;
      if (pg_state == PG_IDLE)
      begin
        pg_is_wr <= pick_wr;
        // an owed read either starts now or is discarded with the enable
        if (rd_follow)
        begin
          rd_follow <= 1'b0;
        end
        else if (qif.pop && port_strobe_enable)
        begin
          rd_follow <= qif.head.also_rd; // [R12]
        end
      end
    end
  end

  // ==========================================================
  // external memory cycle sequencer
  psh_xm_state_t xm_state;
  psh_xm_state_t next_xm_state;
  logic [3:0] xm_cnt;
  logic [3:0] next_xm_cnt;
  logic xm_wr;
  logic xm_sel2;
  logic [15:0] xm_addr_lat;
  logic next_xm_rd;
  logic next_xm_wr;
  logic next_fetch;

  always_comb
  begin
    next_xm_state = xm_state;
    next_xm_cnt = xm_cnt;
    case (xm_state)
      XM_IDLE:
      begin
        if (fetch_req)
        begin
          next_xm_state = XM_FETCH;
          next_xm_cnt = 4'(`PSH_PF_CYC - 1); // [R10]
        end
        else if (xmem_req)
        begin
          next_xm_state = XM_ADDR;
        end
      end
      XM_ADDR:
      begin
        next_xm_state = XM_STB;
        next_xm_cnt = 4'(`PSH_XM_STB_BASE - 1) + {1'b0, stretch}; // [R10]
      end
      XM_STB, XM_FETCH:
      begin
        if (xm_cnt == 4'h0)
        begin
          next_xm_state = XM_IDLE;
        end
        else
        begin
          next_xm_cnt = xm_cnt - 4'h1;
        end
      end
      default:
      begin
        next_xm_state = XM_IDLE;
      end
    endcase
    next_xm_rd = (next_xm_state == XM_STB) && !xm_wr;
    next_xm_wr = (next_xm_state == XM_STB) && xm_wr;
    next_fetch = (next_xm_state == XM_FETCH);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      xm_state <= XM_IDLE;
      xm_cnt <= 4'h0;
      xm_wr <= 1'b0;
      xm_sel2 <= 1'b0;
      xm_addr_lat <= `PSH_RST_ADDR;
    end
    else if (ce)
    begin
      xm_state <= next_xm_state;
      xm_cnt <= next_xm_cnt;
      if (xm_state == XM_IDLE)
      begin
        xm_wr <= xmem_write;
        xm_sel2 <= xmem_use_second && !fetch_req;
        if (fetch_req)
        begin
          xm_addr_lat <= fetch_addr;
        end
        else
        begin
          xm_addr_lat <= xmem_use_second ? second_auto_pointer :
            first_auto_pointer;
        end
      end
    end
  end

  // ==========================================================
  // pin registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      prog_fetch_n <= 1'b1;
      xmem_busy <= 1'b0;
    end
    else if (ce)
    begin
      rd_strobe_n <= !(next_port_rd || next_xm_rd); // [R11]
      wr_strobe_n <= !(next_port_wr || next_xm_wr); // [R11]
      prog_fetch_n <= !next_fetch;
      xmem_busy <= (next_xm_state != XM_IDLE);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      xmem_addr <= `PSH_RST_ADDR;
      xmem_addr_oe <= 1'b0;
    end
    else if (ce)
    begin
      xmem_addr_oe <= 1'b0;
      xmem_addr <= `PSH_RST_ADDR;
      if (next_xm_state == XM_STB || next_xm_state == XM_FETCH ||
        (next_xm_state == XM_ADDR && xmem_use_second && !fetch_req) ||
        (next_xm_state == XM_ADDR && xm_state != XM_IDLE && xm_sel2))
      begin
        xmem_addr_oe <= 1'b1; // [R8] [R9]
        if (xm_state != XM_IDLE)
        begin
          xmem_addr <= xm_addr_lat;
        end
        else if (fetch_req)
        begin
          xmem_addr <= fetch_addr; // [R10]
        end
        else
        begin
          xmem_addr <= second_auto_pointer;
        end
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || !ce);

  wire idle_all = (pg_state == PG_IDLE) && !qif.not_empty &&
    !rd_follow && (xm_state == XM_IDLE);

  write_delay_a: assert property ( // [R3]
    (cpu_port_wr && port_strobe_enable && idle_all && !xmem_req &&
      !fetch_req) |-> wr_strobe_n ##1 wr_strobe_n ##1 wr_strobe_n ##1
      !wr_strobe_n)
    else $error("write strobe not two cycles after port write");
  read_delay_a: assert property ( // [R5]
    (cpu_port_rd && !cpu_port_wr && port_strobe_enable && idle_all &&
      !xmem_req && !fetch_req) |-> rd_strobe_n[*4] ##1 !rd_strobe_n)
    else $error("read strobe not three cycles after port read");
  pulse_width_a: assert property ( // [R2]
    (pg_state == PG_FIRST && xm_state == XM_IDLE && !xmem_req) |->
      (!rd_strobe_n || !wr_strobe_n) ##1 (!rd_strobe_n || !wr_strobe_n)
      ##1 (rd_strobe_n && wr_strobe_n))
    else $error("port strobe not two cycles long");
  enable_gate_a: assert property ( // [R1]
    (!port_strobe_enable && idle_all && !xmem_req && !fetch_req) |=>
      (rd_strobe_n && wr_strobe_n))
    else $error("strobe without port strobe enable");
  idle_high_a: assert property ( // [R11]
    (pg_state == PG_IDLE && xm_state == XM_IDLE) |->
      (rd_strobe_n && wr_strobe_n))
    else $error("strobe low while idle");
  read_value_a: assert property ( // [R4]
    cpu_port_rd |=> (cpu_rd_data == $past(port_in)))
    else $error("port read data not the pins at the read");
  no_sample_a: assert property ( // [R6]
    ($fell(rd_strobe_n) && !$past(cpu_port_rd)) |-> $stable(cpu_rd_data))
    else $error("read data changed on read strobe");
  first_ptr_a: assert property ( // [R8]
    (xmem_addr_oe && !xm_sel2 && prog_fetch_n) |->
      (!rd_strobe_n || !wr_strobe_n))
    else $error("first pointer address outside strobe");
  second_ptr_a: assert property ( // [R9]
    ((xm_state == XM_STB) && xm_sel2) |->
      (xmem_addr_oe && xmem_addr == xm_addr_lat))
    else $error("second pointer address not held");
  fetch_fixed_a: assert property ( // [R10]
    $fell(prog_fetch_n) |-> !prog_fetch_n ##1 !prog_fetch_n ##1 prog_fetch_n)
    else $error("program fetch length changed");
endmodule
`default_nettype wire

// *** psh_periph.sv ***
// peripheral model that feeds bytes into the strobed port
`timescale 1ns/10ps
`default_nettype none
module psh_periph
(
  input wire logic clk,
  input wire logic rd_strobe_n,
  output logic [7:0] port_in
);
  logic prev = 1'b1;
  initial port_in = 8'hA5;
  // next byte only once the read pulse is over
  always @(posedge clk)
  begin
    if (rd_strobe_n === 1'b1 && prev === 1'b0)
      port_in <= port_in + 8'h3B;
    prev <= rd_strobe_n;
  end
endmodule
`default_nettype wire

// *** port_strobe_handshake_test.sv ***
// self-checking bench for the port strobe handshake block
`timescale 1ns/10ps
`default_nettype none
module port_strobe_handshake_test;
  import psh_pkg::*;
  typedef struct {logic w; int st; int wd;} psh_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en, wr, rd, xreq, xwr, xsec, freq, rd_n, wr_n, pf_n, aoe, busy;
  logic [7:0] wdata, drive, port_in, port_out, port_oe, rdata, exp_rd;
  logic [15:0] p1, p2, faddr, addr;
  logic [2:0] str;
  logic [1:0] low = 2'b00;
  int st [2];
  int cyc = 0;
  int free = 0;
  int n_mismatch = 0;
  int n_checks = 0;
  psh_note_t exp_q [$];

  // ==========================================
  // design, peripheral, clock
  psh_top dut
  (
    .clk(clk), .rst(rst), .ce(1'b1), .port_strobe_enable(en),
    .cpu_port_wr(wr), .cpu_port_wr_data(wdata), .cpu_port_rd(rd),
    .port_drive(drive), .port_in(port_in), .port_out(port_out),
    .port_oe(port_oe), .cpu_rd_data(rdata), .xmem_req(xreq),
    .xmem_write(xwr), .xmem_use_second(xsec), .first_auto_pointer(p1),
    .second_auto_pointer(p2), .stretch(str), .fetch_req(freq),
    .fetch_addr(faddr), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n),
    .prog_fetch_n(pf_n), .xmem_addr(addr), .xmem_addr_oe(aoe),
    .xmem_busy(busy)
  );
  psh_periph periph (.clk(clk), .rd_strobe_n(rd_n), .port_in(port_in));
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ==========================================
  // tasks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic idle(int n);
    wr = 1'b0;
    rd = 1'b0;
    repeat (n) step;
  endtask
  // pulses keep access order, one idle cycle between them
  task automatic note(logic w, int due, int wd);
    psh_note_t n;
    n.w = w;
    n.st = (due > free) ? due : free;
    n.wd = wd;
    free = n.st + wd + 1;
    exp_q.push_back(n);
  endtask
  task automatic port_acc(logic w, logic r, logic [7:0] d);
    wr = w;
    rd = r;
    wdata = d;
    drive = 8'($urandom);
    exp_rd = port_in;
    if (en && w) note(1'b1, cyc + 3, 2);
    if (en && r) note(1'b0, cyc + 4, 2);
    step;
    chk("port_oe", {8'h00, drive}, {8'h00, port_oe});
    if (w) chk("port_out", {8'h00, d}, {8'h00, port_out});
    if (r) chk("cpu_rd_data", {8'h00, exp_rd}, {8'h00, rdata});
  endtask
  task automatic xmem(logic w, logic s, logic [2:0] sv);
    p1 = 16'($urandom);
    p2 = 16'($urandom);
    xreq = 1'b1;
    xwr = w;
    xsec = s;
    str = sv;
    note(w, cyc + 2, sv + 1);
    step;
    xreq = 1'b0;
    for (int i = 0; i <= sv + 1; i++)
    begin
      chk("addr enable", {15'h0, s || i > 0}, {15'h0, aoe});
      chk("busy", 16'h1, {15'h0, busy});
      if (s || i > 0) chk("addr", s ? p2 : p1, addr);
      step;
    end
    chk("bus idle", 16'h0, addr | {14'h0, aoe, busy});
  endtask
  task automatic fetch;
    faddr = 16'($urandom);
    str = 3'h7;
    freq = 1'b1;
    step;
    freq = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      chk("fetch strobe", 16'h0, {15'h0, pf_n});
      chk("fetch addr", faddr, addr);
      chk("fetch addr enable", 16'h1, {15'h0, aoe});
      step;
    end
    chk("fetch end", 16'h1, {15'h0, pf_n});
  endtask

  // ==========================================
  // strobe monitor
  always @(negedge clk)
  begin
    psh_note_t n;
    logic pin;
    for (int p = 0; p < 2; p++)
    begin
      pin = p ? wr_n : rd_n;
      if (!rst && pin === 1'b0 && !low[p])
      begin
        low[p] = 1'b1;
        st[p] = cyc;
      end
      else if (pin === 1'b1 && low[p])
      begin
        low[p] = 1'b0;
        if (exp_q.size() == 0)
          chk("unexpected strobe", 16'h0, 16'h1);
        else
        begin
          n = exp_q.pop_front();
          chk("strobe pin", {15'h0, n.w}, {15'h0, p == 1});
          chk("strobe start", n.st[15:0], st[p][15:0]);
          chk("strobe width", n.wd[15:0], cyc[15:0] - st[p][15:0]);
        end
      end
    end
  end

  // ==========================================
  // stimulus
  initial
  begin
    {en, wr, rd, xreq, xwr, xsec, freq} = 7'h00;
    {wdata, drive, p1, p2, faddr, str} = 67'h0;
    void'($urandom(32'h263b));
    repeat (3) step;
    rst = 1'b0;
    step;
    chk("idle strobes", 16'h3, {14'h0, wr_n, rd_n});
    en = 1'b1;
    port_acc(1'b1, 1'b0, 8'($urandom));
    idle(6);
    port_acc(1'b0, 1'b1, 8'h00);
    idle(6);
    en = 1'b0;
    port_acc(1'b1, 1'b0, 8'($urandom));
    port_acc(1'b0, 1'b1, 8'h00);
    idle(8);
    en = 1'b1;
    repeat (6)
    begin
      repeat (3) port_acc($urandom % 2, $urandom % 2, 8'($urandom));
      idle(14);
    end
    port_acc(1'b1, 1'b1, 8'($urandom));
    idle(20);
    for (int i = 0; i < 16; i++) xmem($urandom % 2, i[3], i[2:0]);
    fetch;
    idle(4);
    chk("pending strobes", 16'h0, exp_q.size());
    stop_test;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    stop_test;
  end
endmodule
`default_nettype wire
